// >>> logic/module_sideband_control.sv
`timescale 1ns/1ps
`include "msc_params.svh"

module module_sideband_control #(
    parameter logic [15:0] RST_MIN_CYC = 16'(`MSC_RST_MIN_CYC),
    parameter logic [15:0] INIT_CYC    = 16'(`MSC_INIT_CYC),
    parameter logic [6:0]  DEV_ADDR    = `MSC_DEV_ADDR
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic module_select_n,
    input  wire logic module_reset_n,
    input  wire logic low_power_request,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic fault_event,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      fault_alert_n_out,
    output logic      fault_alert_n_oe,
    output logic      module_present_n_out,
    output logic      module_present_n_oe,
    output logic      power_cap
);
    import msc_pkg::*;

    msc_top_t   s;
    msc_top_t   n;
    msc_acc_t   acc;
    logic [7:0] rd_ptr;
    logic [7:0] rdata;
    logic       clr_done;
    logic       clr_fault;

    // ----------------------------------------
    // Memory map read
    // ----------------------------------------
    function automatic logic [7:0] map_read(input msc_top_t t, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `MSC_OFS_STATUS) begin
            v[`MSC_ST_NRDY] = t.not_ready;
            v[`MSC_ST_LP]   = t.power_cap;
        end else if (a == `MSC_OFS_FLAGS) begin
            v[`MSC_FL_DONE]  = t.flag_done;
            v[`MSC_FL_FAULT] = t.flag_fault;
        end else if (a == `MSC_OFS_CTRL) begin
            v = t.ctrl;
        end else if (a >= `MSC_OFS_SCRATCH && a < `MSC_OFS_SCRATCH + 8'(`MSC_SCRATCH_N)) begin
            v = t.scratch[4'(a - `MSC_OFS_SCRATCH)];
        end
        return v;
    endfunction : map_read

    assign rdata = map_read(s, rd_ptr);

    // ----------------------------------------
    // Two-wire port
    // ----------------------------------------
    msc_twi_slave #(
        .DEV_ADDR        (DEV_ADDR)
    ) u_twi (
        .mclk            (mclk),
        .rst             (rst || s.st == MS_HELD),
        .scl_in          (scl_in),
        .sda_in          (sda_in),
        .module_select_n (module_select_n),
        .rdata           (rdata),
        .sda_oe          (sda_oe),
        .rd_ptr          (rd_ptr),
        .acc             (acc)
    );

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    assign sda_out              = 1'b0;
    assign fault_alert_n_out    = 1'b0;
    assign fault_alert_n_oe     = s.alert_oe;
    assign module_present_n_out = 1'b0;
    assign module_present_n_oe  = 1'b1;
    assign power_cap            = s.power_cap;

    assign clr_done  = acc.rd && acc.addr == `MSC_OFS_FLAGS && s.flag_done;
    assign clr_fault = acc.rd && acc.addr == `MSC_OFS_FLAGS && s.flag_fault;

    // ----------------------------------------
    // Reset sequencing and status
    // ----------------------------------------
    always_comb begin
        n = s;
        n.rstn_m = module_reset_n;
        n.rstn_q = s.rstn_m;
        n.lp_m   = low_power_request;
        n.lp_q   = s.lp_m;
        if (s.rstn_q) begin
            n.low_cnt = 16'h0000;
        end else if (s.low_cnt != RST_MIN_CYC) begin
            n.low_cnt = s.low_cnt + 16'h0001;
        end
        // Host writes and clear-on-read, an event wins over the clear
        if (acc.wr && acc.addr == `MSC_OFS_CTRL) begin
            n.ctrl = acc.wdata;
        end else if (acc.wr && acc.addr >= `MSC_OFS_SCRATCH
                     && acc.addr < `MSC_OFS_SCRATCH + 8'(`MSC_SCRATCH_N)) begin
            n.scratch[4'(acc.addr - `MSC_OFS_SCRATCH)] = acc.wdata;
        end
        n.flag_done = s.flag_done & ~clr_done;
        n.flag_fault = (s.flag_fault & ~clr_fault) | fault_event;
        case (s.st)
            MS_INIT: begin
                n.init_cnt = s.init_cnt + 16'h0001;
                if (s.init_cnt == INIT_CYC - 16'h0001) begin
                    n.st        = MS_READY;
                    n.not_ready = 1'b0;
                    n.flag_done = 1'b1;
                end
            end
            MS_HELD: begin
                if (s.rstn_q) begin
                    n.st       = MS_INIT;
                    n.init_cnt = 16'h0000;
                end
            end
            default: begin
            end
        endcase
        if (s.st != MS_HELD && s.low_cnt == RST_MIN_CYC - 16'h0001 && !s.rstn_q) begin
            n.st         = MS_HELD;
            n.not_ready  = 1'b1;
            n.flag_done  = 1'b0;
            n.flag_fault = fault_event;
            n.ctrl       = `MSC_CTRL_RST;
            n.scratch    = {`MSC_SCRATCH_N{`MSC_SCRATCH_RST}};
        end
        n.power_cap = s.lp_q | s.ctrl[`MSC_CT_LP];
        n.alert_oe  = n.flag_done | n.flag_fault;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s           <= '0;
            s.st        <= MS_INIT;
            s.rstn_m    <= 1'b1;
            s.rstn_q    <= 1'b1;
            s.not_ready <= 1'b1;
            s.ctrl      <= `MSC_CTRL_RST;
            s.scratch   <= {`MSC_SCRATCH_N{`MSC_SCRATCH_RST}};
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence done_seq;
        $fell(s.not_ready) ##0 s.flag_done;
    endsequence

    held_notready_a: assert property ($rose(s.st == MS_HELD) |-> s.not_ready && s.ctrl == `MSC_CTRL_RST)
        else $error("qualified reset did not restore defaults");
    completion_int_a: assert property (done_seq |-> fault_alert_n_oe && $past(s.st) == MS_INIT)
        else $error("completion without alert");
    powerup_init_a: assert property ($fell(rst) |-> s.st == MS_INIT && s.not_ready && s.init_cnt == 16'h0000)
        else $error("power-up did not start init");
    low_power_a: assert property (s.lp_q |=> power_cap)
        else $error("power cap not applied");
    present_low_a: assert property (module_present_n_oe && !module_present_n_out)
        else $error("presence not pulled low");
    fault_alert_a: assert property (fault_event |=> s.flag_fault ##0 fault_alert_n_oe)
        else $error("fault did not raise alert");
    alert_opendrain_a: assert property (!fault_alert_n_out)
        else $error("alert driven high");
    notready_hold_a: assert property (s.st != MS_READY |-> s.not_ready)
        else $error("not-ready cleared early");
    short_pulse_a: assert property ($rose(s.st == MS_HELD) |-> $past(s.low_cnt) == RST_MIN_CYC - 16'h0001)
        else $error("reset taken before minimum width");

endmodule : module_sideband_control

// >>> logic/msc_params.svh
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define MSC_CLK_NS        5
`define MSC_RST_MIN_NS    10000
`define MSC_RST_MIN_CYC   ((`MSC_RST_MIN_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS)
`define MSC_INIT_NS       2000
`define MSC_INIT_CYC      (`MSC_INIT_NS / `MSC_CLK_NS)

// ----------------------------------------
// Two-wire address and memory map
// ----------------------------------------
`define MSC_DEV_ADDR      7'h50
`define MSC_OFS_STATUS    8'h00
`define MSC_OFS_FLAGS     8'h01
`define MSC_OFS_CTRL      8'h02
`define MSC_OFS_SCRATCH   8'h04
`define MSC_SCRATCH_N     16

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MSC_ST_NRDY       0
`define MSC_ST_LP         1
`define MSC_FL_DONE       0
`define MSC_FL_FAULT      1
`define MSC_CT_LP         0
`define MSC_CTRL_RST      8'h00
`define MSC_SCRATCH_RST   8'h00

`endif

// >>> logic/msc_pkg.sv
`include "msc_params.svh"

package msc_pkg;

    typedef enum logic [6:0] {
        SL_IDLE  = 7'h01,
        SL_ADDR  = 7'h02,
        SL_ACK_A = 7'h04,
        SL_WR    = 7'h08,
        SL_ACK_W = 7'h10,
        SL_RD    = 7'h20,
        SL_ACK_R = 7'h40
    } msc_twi_state_t;

    typedef enum logic [2:0] {
        MS_INIT  = 3'h1,
        MS_READY = 3'h2,
        MS_HELD  = 3'h4
    } msc_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msc_acc_t;

    typedef struct packed {
        logic           scl_m, scl_q, scl_p;
        logic           sda_m, sda_q, sda_p;
        logic           sel_m, sel_q;
        msc_twi_state_t st;
        logic [3:0]     cnt;
        logic [7:0]     sh;
        logic [7:0]     ptr;
        logic           ptr_set;
        logic           rw;
        logic           nack;
        logic           oe;
        msc_acc_t       acc;
    } msc_twi_t;

    typedef struct packed {
        logic                             rstn_m, rstn_q;
        logic                             lp_m, lp_q;
        msc_mode_t                        st;
        logic [15:0]                      low_cnt;
        logic [15:0]                      init_cnt;
        logic                             not_ready;
        logic                             flag_done;
        logic                             flag_fault;
        logic [7:0]                       ctrl;
        logic [`MSC_SCRATCH_N-1:0][7:0]   scratch;
        logic                             alert_oe;
        logic                             power_cap;
    } msc_top_t;

endpackage : msc_pkg

// >>> logic/msc_twi_slave.sv
`timescale 1ns/1ps
`include "msc_params.svh"

module msc_twi_slave #(
    parameter logic [6:0] DEV_ADDR = `MSC_DEV_ADDR
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    input  wire logic              module_select_n,
    input  wire logic [7:0]        rdata,
    output logic                   sda_oe,
    output logic [7:0]             rd_ptr,
    output msc_pkg::msc_acc_t      acc
);
    import msc_pkg::*;

    msc_twi_t s;
    msc_twi_t n;
    logic     start;
    logic     stop;
    logic     rise;
    logic     fall;

    assign start  = s.scl_q & s.scl_p & s.sda_p & ~s.sda_q;
    assign stop   = s.scl_q & s.scl_p & ~s.sda_p & s.sda_q;
    assign rise   = s.scl_q & ~s.scl_p;
    assign fall   = ~s.scl_q & s.scl_p;
    assign sda_oe = s.oe;
    assign rd_ptr = s.ptr;
    assign acc    = s.acc;

    always_comb begin
        n = s;
        n.scl_m = scl_in;
        n.scl_q = s.scl_m;
        n.scl_p = s.scl_q;
        n.sda_m = sda_in;
        n.sda_q = s.sda_m;
        n.sda_p = s.sda_q;
        n.sel_m = module_select_n;
        n.sel_q = s.sel_m;
        n.acc.wr = 1'b0;
        n.acc.rd = 1'b0;
        if (s.sel_q) begin
            n.st = SL_IDLE;
            n.oe = 1'b0;
        end else if (start) begin
            n.st      = SL_ADDR;
            n.cnt     = 4'h0;
            n.oe      = 1'b0;
            n.ptr_set = 1'b0;
        end else if (stop) begin
            n.st = SL_IDLE;
            n.oe = 1'b0;
        end else begin
            case (s.st)
                SL_ADDR, SL_WR: begin
                    if (rise) begin
                        n.sh  = {s.sh[6:0], s.sda_q};
                        n.cnt = s.cnt + 4'h1;
                    end else if (fall && s.cnt == 4'h8) begin
                        n.oe = 1'b1;
                        if (s.st == SL_ADDR) begin
                            n.rw = s.sh[0];
                            n.st = (s.sh[7:1] == DEV_ADDR) ? SL_ACK_A : SL_IDLE;
                            n.oe = (s.sh[7:1] == DEV_ADDR);
                        end else begin
                            n.st = SL_ACK_W;
                            if (!s.ptr_set) begin
                                n.ptr     = s.sh;
                                n.ptr_set = 1'b1;
                            end else begin
                                n.acc.wr    = 1'b1;
                                n.acc.addr  = s.ptr;
                                n.acc.wdata = s.sh;
                                n.ptr       = s.ptr + 8'h01;
                            end
                        end
                    end
                end
                SL_ACK_A, SL_ACK_W, SL_ACK_R: begin
                    if (rise && s.st == SL_ACK_R) begin
                        n.nack = s.sda_q;
                    end else if (fall) begin
                        n.cnt = 4'h0;
                        if ((s.st == SL_ACK_A && s.rw) || (s.st == SL_ACK_R && !s.nack)) begin
                            n.st       = SL_RD;
                            n.sh       = rdata;
                            n.oe       = ~rdata[7];
                            n.acc.rd   = 1'b1;
                            n.acc.addr = s.ptr;
                            n.ptr      = s.ptr + 8'h01;
                        end else begin
                            n.oe = 1'b0;
                            n.st = (s.st == SL_ACK_R) ? SL_IDLE : SL_WR;
                        end
                    end
                end
                SL_RD: begin
                    if (rise) begin
                        n.cnt = s.cnt + 4'h1;
                    end else if (fall) begin
                        if (s.cnt == 4'h8) begin
                            n.oe = 1'b0;
                            n.st = SL_ACK_R;
                        end else begin
                            n.sh = {s.sh[6:0], 1'b0};
                            n.oe = ~s.sh[6];
                        end
                    end
                end
                default: begin
                    n.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s       <= '0;
            s.st    <= SL_IDLE;
            s.sel_m <= 1'b1;
            s.sel_q <= 1'b1;
            s.scl_m <= 1'b1;
            s.scl_q <= 1'b1;
            s.scl_p <= 1'b1;
            s.sda_m <= 1'b1;
            s.sda_q <= 1'b1;
            s.sda_p <= 1'b1;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    select_gate_a: assert property (s.sel_q |=> !sda_oe && s.st == SL_IDLE)
        else $error("data line driven while deselected");
    addr_ack_a: assert property ((s.st == SL_ADDR) && fall && s.cnt == 4'h8 && s.sh[7:1] != DEV_ADDR
        && !s.sel_q && !start && !stop |=> !sda_oe && s.st == SL_IDLE)
        else $error("foreign address acknowledged");

endmodule : msc_twi_slave

// >>> verification/msc_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Host two-wire master with pull-up on data
// ----------------------------------------
module msc_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    input  wire logic mclk,
    input  wire logic sda_oe,
    output logic      scl_in,
    output logic      sda_in
);
    logic scl_drv;
    logic sda_low;

    // Wired-and data line, high when nobody pulls
    assign scl_in = scl_drv;
    assign sda_in = ~(sda_low | sda_oe);

    initial begin
        scl_drv = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n

    task automatic bit_io(input logic b, output logic r);
        wait_n(6);
        sda_low = ~b;
        wait_n(7);
        scl_drv = 1'b1;
        wait_n(6);
        r = sda_in;
        wait_n(6);
        scl_drv = 1'b0;
    endtask : bit_io

    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack_out);
    endtask : byte_io

    task automatic start_c;
        wait_n(6);
        sda_low = 1'b0;
        wait_n(7);
        scl_drv = 1'b1;
        wait_n(12);
        sda_low = 1'b1;
        wait_n(12);
        scl_drv = 1'b0;
    endtask : start_c

    task automatic stop_c;
        wait_n(6);
        sda_low = 1'b1;
        wait_n(7);
        scl_drv = 1'b1;
        wait_n(12);
        sda_low = 1'b0;
        wait_n(12);
    endtask : stop_c

    task automatic xfer_write(input logic [7:0] ptr, input logic [7:0] d0, output logic acked);
        logic [7:0] q;
        logic a0, a1, a2;
        start_c();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a0);
        byte_io(ptr, 1'b1, q, a1);
        byte_io(d0, 1'b1, q, a2);
        stop_c();
        acked = ~(a0 | a1 | a2);
    endtask : xfer_write

    // repeated start read, ack continues, nack ends
    task automatic xfer_read(input logic [7:0] ptr, input int n, output logic [7:0] q0, output logic [7:0] q1);
        logic [7:0] q;
        logic a;
        start_c();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, q, a);
        byte_io(ptr, 1'b1, q, a);
        start_c();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, q, a);
        byte_io(8'hff, n == 1, q0, a);
        q1 = 8'h00;
        if (n == 2) begin
            byte_io(8'hff, 1'b1, q1, a);
        end
        stop_c();
    endtask : xfer_read
endmodule : msc_host_model

// >>> verification/module_sideband_control_tb_top.sv
`timescale 1ns/1ps

module module_sideband_control_tb_top;
    logic       mclk;
    logic       rst;
    logic       module_select_n;
    logic       module_reset_n;
    logic       low_power_request;
    logic       fault_event;
    logic       scl_in;
    logic       sda_in;
    logic       sda_out;
    logic       sda_oe;
    logic       fault_alert_n_out;
    logic       fault_alert_n_oe;
    logic       module_present_n_out;
    logic       module_present_n_oe;
    logic       power_cap;
    logic       alert_n_w;
    logic       present_n_w;
    logic [7:0] q0;
    logic [7:0] q1;
    logic       ack;
    int         err_count;
    int         tests_run;

    // ----------------------------------------
    // Harness
    // ----------------------------------------
    assign alert_n_w   = fault_alert_n_oe ? fault_alert_n_out : 1'b1;
    assign present_n_w = module_present_n_oe ? module_present_n_out : 1'b1;

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    module_sideband_control #(
        .RST_MIN_CYC(16'h0008),
        .INIT_CYC   (16'h07d0),
        .DEV_ADDR   (7'h50)
    ) module_sideband_control_inst (
        .mclk                (mclk),
        .rst                 (rst),
        .module_select_n     (module_select_n),
        .module_reset_n      (module_reset_n),
        .low_power_request   (low_power_request),
        .scl_in              (scl_in),
        .sda_in              (sda_in),
        .fault_event         (fault_event),
        .sda_out             (sda_out),
        .sda_oe              (sda_oe),
        .fault_alert_n_out   (fault_alert_n_out),
        .fault_alert_n_oe    (fault_alert_n_oe),
        .module_present_n_out(module_present_n_out),
        .module_present_n_oe (module_present_n_oe),
        .power_cap           (power_cap)
    );

    msc_host_model #(
        .DEV_ADDR(7'h50)
    ) msc_host_model_inst (
        .mclk  (mclk),
        .sda_oe(sda_oe),
        .scl_in(scl_in),
        .sda_in(sda_in)
    );

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic wait_alert(input logic lvl, input int bound);
        for (int i = 0; i < bound && alert_n_w !== lvl; i++) begin
            @(negedge mclk);
        end
        if (alert_n_w !== lvl) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, alert_n_w, lvl);
            close_out();
        end
    endtask : wait_alert

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_power_up;
        msc_host_model_inst.xfer_read(8'h00, 1, q0, q1);
        check8(q0, 8'h01);
        // status trusted only after completion alert
        wait_alert(1'b0, 3000);
        check8({7'h00, fault_alert_n_out}, 8'h00);
        msc_host_model_inst.xfer_read(8'h00, 1, q0, q1);
        check8(q0, 8'h00);
        msc_host_model_inst.xfer_read(8'h01, 1, q0, q1);
        check8(q0, 8'h01);
        check8({7'h00, alert_n_w}, 8'h01);
        check8({7'h00, present_n_w}, 8'h00);
        check8({7'h00, sda_out}, 8'h00);
    endtask : sc_power_up

    task automatic sc_select;
        msc_host_model_inst.xfer_write(8'h04, 8'ha5, ack);
        check8({7'h00, ack}, 8'h01);
        msc_host_model_inst.xfer_write(8'h05, 8'h3c, ack);
        // this module's select is deasserted, so the write must not be acknowledged
        module_select_n = 1'b1;
        msc_host_model_inst.xfer_write(8'h04, 8'h11, ack);
        check8({7'h00, ack}, 8'h00);
        module_select_n = 1'b0;
        msc_host_model_inst.xfer_read(8'h04, 2, q0, q1);
        check8(q0, 8'ha5);
        check8(q1, 8'h3c);
    endtask : sc_select

    task automatic sc_low_power;
        low_power_request = 1'b1;
        repeat (10) @(negedge mclk);
        check8({7'h00, power_cap}, 8'h01);
        msc_host_model_inst.xfer_read(8'h00, 1, q0, q1);
        check8(q0, 8'h02);
        low_power_request = 1'b0;
        repeat (10) @(negedge mclk);
        check8({7'h00, power_cap}, 8'h00);
        msc_host_model_inst.xfer_write(8'h02, 8'h01, ack);
        repeat (10) @(negedge mclk);
        check8({7'h00, power_cap}, 8'h01);
        msc_host_model_inst.xfer_read(8'h02, 1, q0, q1);
        check8(q0, 8'h01);
    endtask : sc_low_power

    task automatic sc_reset_pin;
        module_reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        module_reset_n = 1'b1;
        repeat (3000) @(negedge mclk);
        check8({7'h00, alert_n_w}, 8'h01);
        check8({7'h00, power_cap}, 8'h01);
        module_reset_n = 1'b0;
        repeat (20) @(negedge mclk);
        module_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        check8({7'h00, power_cap}, 8'h00);
        wait_alert(1'b0, 3000);
        msc_host_model_inst.xfer_read(8'h04, 2, q0, q1);
        check8(q0, 8'h00);
        check8(q1, 8'h00);
        msc_host_model_inst.xfer_read(8'h01, 1, q0, q1);
        check8(q0, 8'h01);
    endtask : sc_reset_pin

    task automatic sc_fault;
        check8({7'h00, alert_n_w}, 8'h01);
        fault_event = 1'b1;
        @(negedge mclk);
        fault_event = 1'b0;
        wait_alert(1'b0, 10);
        msc_host_model_inst.xfer_read(8'h01, 1, q0, q1);
        check8(q0, 8'h02);
        check8({7'h00, alert_n_w}, 8'h01);
    endtask : sc_fault

    initial begin
        rst               = 1'b1;
        module_select_n   = 1'b0;
        module_reset_n    = 1'b1;
        low_power_request = 1'b0;
        fault_event       = 1'b0;
        err_count         = 0;
        tests_run         = 0;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        sc_power_up();
        sc_select();
        sc_low_power();
        sc_reset_pin();
        sc_fault();
        close_out();
    end
endmodule : module_sideband_control_tb_top
